//--- design/instr_cycle_divider.v
// instruction-cycle divider: one-cycle enable pulse every INSTR_DIV_CYCLES clocks
// assumes a single free-running clock and asynchronous active-high reset
`timescale 1ns/100ps
`include "timer_skip_map.vh"

module instr_cycle_divider (
    input  wire clk,        // system clock
    input  wire rst,        // async reset, active high
    output reg  cycleEn_r   // one-clock pulse per instruction cycle
);

    reg  [`DIV_WIDTH-1:0] divCnt_r;
    wire [`DIV_WIDTH-1:0] divLast = `INSTR_DIV_LAST;

    // ----------------------------------------------------------------
    // counter
    // ----------------------------------------------------------------
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            divCnt_r  <= {`DIV_WIDTH{1'b0}};
            cycleEn_r <= 1'b0;
        end else if (divCnt_r == divLast) begin
            divCnt_r  <= {`DIV_WIDTH{1'b0}};
            cycleEn_r <= 1'b1;
        end else begin
            divCnt_r  <= divCnt_r + {{(`DIV_WIDTH-1){1'b0}}, 1'b1};
            cycleEn_r <= 1'b0;
        end
    end

endmodule // instr_cycle_divider

//--- design/timer_flag_skip_decode.v
// decoder and flag logic for the skip-on-timer-flag instructions of timers C and D
// and the software system reset instruction
// assumes instrWord/instrValid are held stable across each instruction cycle
// and that the core squashes the next instruction while skipNext is high
// one word per instruction slot; the slot strobe comes from instr_cycle_divider
`timescale 1ns/100ps
`include "timer_skip_map.vh"

module timer_flag_skip_decode (
    input  wire                        clk,              // 125 MHz system clock
    input  wire                        rst,              // async reset, active high
    input  wire                        instrValid,       // fetched word is valid
    input  wire [`OP_WIDTH-1:0]        instrWord,        // fetched instruction word
    input  wire [`IRQ_CTRL_WIDTH-1:0]  irqControlSecond, // second interrupt control reg
    input  wire                        timerCEvent,      // timer C underflow pulse
    input  wire                        timerDEvent,      // timer D underflow pulse
    input  wire                        timerCIrqAck,     // interrupt taken for timer C
    input  wire                        timerDIrqAck,     // interrupt taken for timer D
    output reg                         timerCIrqFlag_r,  // timer C request flag
    output reg                         timerDIrqFlag_r,  // timer D request flag
    output reg                         skipNext_r,       // next instruction is squashed
    output reg                         sysResetReq_r,    // system reset request
    output reg                         opDone_r,         // pulse: instruction executed
    output reg  [`OPC_WIDTH-1:0]       opClass_r,        // class of executed instruction
    output reg                         instrCycle_r      // copy of instruction-cycle enable
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // a test skips only when its enable is clear and its flag is set
    function skipTaken;
        input enableBit;
        input flagBit;
        begin
            skipTaken = ~enableBit & flagBit;
        end
    endfunction

    // next flag value: set wins over any clear in the same cycle
    function flagNext;
        input flagBit;
        input setEvt;
        input clrEvt;
        begin
            flagNext = setEvt | (flagBit & ~clrEvt);
        end
    endfunction

    // opcode compare, shared by the isTestC/isTestD/isReset decodes below
    function opMatch;
        input [`OP_WIDTH-1:0] word;
        input [`OP_WIDTH-1:0] code;
        begin
            opMatch = (word == code);
        end
    endfunction

    // class reported for a live word; a test with its enable set is a no-operation
    function [`OPC_WIDTH-1:0] opClassOf;
        input [`OP_WIDTH-1:0] word;
        input                 enC;
        input                 enD;
        begin
            case (word)
                `OP_SKIP_TIMER_C: begin
                    opClassOf = enC ? `OPC_AS_NOP : `OPC_SKIP_TEST;
                end
                `OP_SKIP_TIMER_D: begin
                    opClassOf = enD ? `OPC_AS_NOP : `OPC_SKIP_TEST;
                end
                `OP_SYS_RESET: begin
                    opClassOf = `OPC_SYS_RESET;
                end
                default: begin
                    opClassOf = `OPC_OTHER;
                end
            endcase
        end
    endfunction

    // ----------------------------------------------------------------
    // instruction-cycle enable
    // ----------------------------------------------------------------
    wire cycleEn;

    instr_cycle_divider uDivider (
        .clk       (clk),
        .rst       (rst),
        .cycleEn_r (cycleEn)
    );

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    // one word executes in exactly one instruction cycle
    wire execute  = cycleEn & instrValid & ~sysResetReq_r;
    // squashed words still let timer events and acks through to the flags
    wire squashed = execute & skipNext_r;
    wire live     = execute & ~skipNext_r;

    wire isTestC  = live & opMatch(instrWord, `OP_SKIP_TIMER_C);
    wire isTestD  = live & opMatch(instrWord, `OP_SKIP_TIMER_D);
    wire isReset  = live & opMatch(instrWord, `OP_SYS_RESET);

    wire enableC  = irqControlSecond[`IRQ_EN_TIMER_C_BIT];
    wire enableD  = irqControlSecond[`IRQ_EN_TIMER_D_BIT];

    wire skipC    = isTestC & skipTaken(enableC, timerCIrqFlag_r);
    wire skipD    = isTestD & skipTaken(enableD, timerDIrqFlag_r);

    // ----------------------------------------------------------------
    // next-state logic
    // ----------------------------------------------------------------
    reg                         timerCIrqFlag_nxt;
    reg                         timerDIrqFlag_nxt;
    reg                         skipNext_nxt;
    reg  [`OPC_WIDTH-1:0]       opClass_nxt;

    always @* begin
        // a skip clears its own flag; a late timer event still survives
        timerCIrqFlag_nxt = flagNext(timerCIrqFlag_r, timerCEvent,
                                     skipC | timerCIrqAck);
        timerDIrqFlag_nxt = flagNext(timerDIrqFlag_r, timerDEvent,
                                     skipD | timerDIrqAck);
        skipNext_nxt = skipNext_r;
        if (squashed) begin
            skipNext_nxt = 1'b0;
        end
        if (live) begin
            skipNext_nxt = skipC | skipD;
        end
        opClass_nxt = opClass_r;
        // a squashed word leaves the reported class alone
        if (live) begin
            opClass_nxt = opClassOf(instrWord, enableC, enableD);
        end
    end

    // ----------------------------------------------------------------
    // software system reset
    // ----------------------------------------------------------------
    // request is held long enough for every block to see it, then drops
    // timer events landing while it is high are lost, as under external reset
    reg  [`RESET_CNT_WIDTH-1:0] resetCnt_r;
    wire                        resetEnd  = sysResetReq_r & (resetCnt_r == `SYS_RESET_LAST);

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            sysResetReq_r <= 1'b0;
            resetCnt_r    <= {`RESET_CNT_WIDTH{1'b0}};
        end else if (isReset) begin
            sysResetReq_r <= 1'b1;
            resetCnt_r    <= {`RESET_CNT_WIDTH{1'b0}};
        end else if (resetEnd) begin
            sysResetReq_r <= 1'b0;
            resetCnt_r    <= {`RESET_CNT_WIDTH{1'b0}};
        end else if (sysResetReq_r) begin
            resetCnt_r    <= resetCnt_r + {{(`RESET_CNT_WIDTH-1){1'b0}}, 1'b1};
        end
    end

    // ----------------------------------------------------------------
    // request flags
    // ----------------------------------------------------------------
    // software reset acts like the external one on everything here
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            timerCIrqFlag_r <= 1'b0;
            timerDIrqFlag_r <= 1'b0;
        end else if (sysResetReq_r) begin
            timerCIrqFlag_r <= 1'b0;
            timerDIrqFlag_r <= 1'b0;
        end else begin
            timerCIrqFlag_r <= timerCIrqFlag_nxt;
            timerDIrqFlag_r <= timerDIrqFlag_nxt;
        end
    end

    // ----------------------------------------------------------------
    // skip sequencing
    // ----------------------------------------------------------------
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            skipNext_r <= 1'b0;
        end else if (sysResetReq_r) begin
            skipNext_r <= 1'b0;
        end else begin
            skipNext_r <= skipNext_nxt;
        end
    end

    // ----------------------------------------------------------------
    // execution report
    // ----------------------------------------------------------------
    // instrCycle_r keeps running through a software reset so slots stay visible
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            opClass_r    <= `OPC_OTHER;
            opDone_r     <= 1'b0;
            instrCycle_r <= 1'b0;
        end else if (sysResetReq_r) begin
            opClass_r    <= `OPC_OTHER;
            opDone_r     <= 1'b0;
            instrCycle_r <= cycleEn;
        end else begin
            opClass_r    <= opClass_nxt;
            opDone_r     <= live;
            instrCycle_r <= cycleEn;
        end
    end

endmodule // timer_flag_skip_decode

//--- design/timer_skip_map.vh
// constants for the timer flag skip decoder: opcodes, bit positions, timing
// assumes inclusion by bare name from design files under design/
`ifndef TIMER_SKIP_MAP_VH
`define TIMER_SKIP_MAP_VH

// ----------------------------------------------------------------
// instruction words
// ----------------------------------------------------------------
`define OP_WIDTH            10
`define OP_SKIP_TIMER_C     10'h282
`define OP_SKIP_TIMER_D     10'h283
`define OP_SYS_RESET        10'h001

// ----------------------------------------------------------------
// second interrupt control register layout
// ----------------------------------------------------------------
`define IRQ_CTRL_WIDTH      4
`define IRQ_EN_TIMER_C_BIT  0
`define IRQ_EN_TIMER_D_BIT  1

// ----------------------------------------------------------------
// executed-operation classes reported on opClass
// ----------------------------------------------------------------
`define OPC_WIDTH           2
`define OPC_OTHER           2'h0
`define OPC_SKIP_TEST       2'h1
`define OPC_AS_NOP          2'h2
`define OPC_SYS_RESET       2'h3

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS       8
`define INSTR_CYCLE_NS      32
`define INSTR_DIV_CYCLES    (`INSTR_CYCLE_NS / `CLK_PERIOD_NS)
// last divider count, kept equal to INSTR_DIV_CYCLES - 1 at DIV_WIDTH bits
`define INSTR_DIV_LAST      3'h3
`define DIV_WIDTH           3
`define SYS_RESET_NS        64
`define SYS_RESET_CYCLES    (`SYS_RESET_NS / `CLK_PERIOD_NS)
// last reset count, kept equal to SYS_RESET_CYCLES - 1 at RESET_CNT_WIDTH bits
`define SYS_RESET_LAST      4'h7
`define RESET_CNT_WIDTH     4

`endif

//--- verif/tb_top.sv
// self-checking bench for the timer flag skip decoder
// assumes the decoder and its checker are compiled first
`timescale 1ns/100ps
`include "timer_skip_map.vh"
module tb_top;
    reg                       clk = 0, rst = 1, instrValid = 0, pend = 0, flagCExp = 0, flagDExp = 0;
    reg [`OP_WIDTH-1:0]       instrWord = 0;
    reg [`IRQ_CTRL_WIDTH-1:0] irqControlSecond = 0;
    reg                       evC = 0, evD = 0, ackC = 0, ackD = 0;
    wire                      flagC, flagD, skipNext, sysReq, opDone, slot;
    wire [`OPC_WIDTH-1:0]     opClass;
    integer                   err_count = 0, comparisons = 0, n, i;
    reg [31:0]                r;
    reg [`OP_WIDTH-1:0]       randWord;
    reg [4:0]                 q[$];
    timer_flag_skip_decode DUT (.clk(clk), .rst(rst), .instrValid(instrValid),
        .instrWord(instrWord), .irqControlSecond(irqControlSecond), .timerCEvent(evC),
        .timerDEvent(evD), .timerCIrqAck(ackC), .timerDIrqAck(ackD), .timerCIrqFlag_r(flagC),
        .timerDIrqFlag_r(flagD), .skipNext_r(skipNext), .sysResetReq_r(sysReq),
        .opDone_r(opDone), .opClass_r(opClass), .instrCycle_r(slot));
    initial forever #4 clk = ~clk;
    task check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        comparisons = comparisons + 1;
        if (seen !== exp) begin
            err_count = err_count + 1;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task stop_test;
        if (err_count == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // ------------------------------------------------------------
    // one instruction per slot; the flag model tracks set-wins-over-ack
    // ------------------------------------------------------------
    task do_op(input [9:0] wd, input [3:0] ct, input [3:0] ev);
        reg sq;
        n = 0;
        while (slot !== 1'b1) begin
            n = n + 1;
            if (n > 20) begin err_count = err_count + 1; stop_test; end
            @(posedge clk) #1;
        end
        sq = pend;
        instrWord = wd;
        instrValid = 1;
        irqControlSecond = ct;
        {ackD, ackC, evD, evC} = ev;
        flagCExp = ev[0] | (flagCExp & ~ev[2]);
        flagDExp = ev[1] | (flagDExp & ~ev[3]);
        @(posedge clk) #1;
        {ackD, ackC, evD, evC} = 4'h0;
        if (sq) pend = 0;
        else if (wd == `OP_SKIP_TIMER_C) begin
            pend = !ct[0] && flagCExp;
            q.push_back({ct[0] ? `OPC_AS_NOP : `OPC_SKIP_TEST, pend, flagCExp & !pend, flagDExp});
            flagCExp = flagCExp & !pend;
        end else if (wd == `OP_SKIP_TIMER_D) begin
            pend = !ct[1] && flagDExp;
            q.push_back({ct[1] ? `OPC_AS_NOP : `OPC_SKIP_TEST, pend, flagCExp, flagDExp & !pend});
            flagDExp = flagDExp & !pend;
        end else if (wd != `OP_SYS_RESET) q.push_back({`OPC_OTHER, 1'b0, flagCExp, flagDExp});
        repeat (3) @(posedge clk);
        #1;
        if (sq) check("squash", {skipNext, opDone}, 0);
    endtask
    always @(negedge clk)
        if (opDone === 1'b1 && opClass !== `OPC_SYS_RESET) begin
            if (q.size() == 0) check("spare result", 1, 0);
            else check("result", {opClass, skipNext, flagC, flagD}, q.pop_front());
        end
    initial begin
        r = $urandom(66497);
        repeat (2) @(posedge clk);
        #1 rst = 0;
        do_op(`OP_SKIP_TIMER_C, 4'h0, 4'h1);
        do_op(`OP_SKIP_TIMER_D, 4'h0, 4'h2);
        do_op(`OP_SKIP_TIMER_D, 4'hE, 4'h0);
        do_op(`OP_SKIP_TIMER_D, 4'h1, 4'h0);
        for (i = 0; i < 60; i = i + 1) begin
            r = $urandom;
            randWord = r[0] ? `OP_SKIP_TIMER_C : `OP_SKIP_TIMER_D;
            if (r[1] & r[2] && r[20:11] != `OP_SKIP_TIMER_C &&
                r[20:11] != `OP_SKIP_TIMER_D && r[20:11] != `OP_SYS_RESET) randWord = r[20:11];
            do_op(randWord, r[6:3], r[10:7]);
        end
        do_op(10'h000, 4'h0, 4'h0);
        do_op(`OP_SYS_RESET, 4'h0, 4'h3);
        instrValid = 0;
        n = 0;
        while (sysReq === 1'b1 && n < 20) begin n = n + 1; @(posedge clk) #1; end
        check("reset length", n, `SYS_RESET_CYCLES);
        @(posedge clk) #1;
        check("state after reset", {skipNext, flagC, flagD}, 0);
        {flagCExp, flagDExp, pend} = 3'h0;
        do_op(`OP_SKIP_TIMER_C, 4'h0, 4'h0);
        repeat (4) @(posedge clk);
        check("pending results", q.size(), 0);
        stop_test;
    end
endmodule // tb_top

//--- verif/timer_skip_sva.sv
// assertions on the timer flag skip decoder ports
// assumes binding onto timer_flag_skip_decode, one clock domain
`timescale 1ns/100ps
`include "timer_skip_map.vh"
module timer_skip_sva (
    input wire                       clk,              // clock
    input wire                       rst,              // reset
    input wire                       instrValid,       // word valid
    input wire [`OP_WIDTH-1:0]       instrWord,        // word
    input wire [`IRQ_CTRL_WIDTH-1:0] irqControlSecond, // enables
    input wire                       timerCEvent,      // set C
    input wire                       timerDEvent,      // set D
    input wire                       timerCIrqFlag_r,  // flag C
    input wire                       timerDIrqFlag_r,  // flag D
    input wire                       skipNext_r,       // skip
    input wire                       sysResetReq_r,    // soft reset
    input wire                       opDone_r,         // done
    input wire [`OPC_WIDTH-1:0]      opClass_r,        // class
    input wire                       instrCycle_r      // slot seen
);
    // ------------------------------------------------------------
    // slot take condition
    // ------------------------------------------------------------
    wire live = instrValid && !skipNext_r && !sysResetReq_r;
    wire [1:0] en = irqControlSecond[1:0];
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_skip_c: assert property (instrCycle_r && $past(live && instrWord == `OP_SKIP_TIMER_C &&
        !en[0] && timerCIrqFlag_r) |-> skipNext_r && opClass_r == `OPC_SKIP_TEST &&
        (!timerCIrqFlag_r || $past(timerCEvent))) else $error("timer C skip wrong");
    a_nop_c: assert property (instrCycle_r && $past(live && instrWord == `OP_SKIP_TIMER_C &&
        en[0]) |-> !skipNext_r && opClass_r == `OPC_AS_NOP) else $error("timer C nop wrong");
    a_skip_d: assert property (instrCycle_r && $past(live && instrWord == `OP_SKIP_TIMER_D &&
        !en[1] && timerDIrqFlag_r) |-> skipNext_r && opClass_r == `OPC_SKIP_TEST &&
        (!timerDIrqFlag_r || $past(timerDEvent))) else $error("timer D skip wrong");
    a_nop_d: assert property (instrCycle_r && $past(live && instrWord == `OP_SKIP_TIMER_D &&
        en[1]) |-> !skipNext_r && opClass_r == `OPC_AS_NOP) else $error("timer D nop wrong");
    a_zero_run: assert property (instrCycle_r && $past(live && (
        instrWord == `OP_SKIP_TIMER_C && !en[0] && !timerCIrqFlag_r ||
        instrWord == `OP_SKIP_TIMER_D && !en[1] && !timerDIrqFlag_r)) |->
        !skipNext_r && opClass_r == `OPC_SKIP_TEST) else $error("zero flag skipped");
    a_squash_next: assert property (instrCycle_r && $past(instrValid && skipNext_r &&
        !sysResetReq_r) |-> !skipNext_r && !opDone_r && $stable(opClass_r))
        else $error("squash wrong");
    a_done_slot: assert property (opDone_r |-> instrCycle_r ##1 !opDone_r)
        else $error("done pulse wrong");
    a_reset_op: assert property (instrCycle_r && $past(live && instrWord == `OP_SYS_RESET)
        |-> sysResetReq_r && opClass_r == `OPC_SYS_RESET) else $error("reset op missed");
    a_reset_len: assert property ($rose(sysResetReq_r) |-> sysResetReq_r[*8] ##1
        !sysResetReq_r) else $error("reset length wrong");
endmodule // timer_skip_sva

bind timer_flag_skip_decode timer_skip_sva u_sva (.clk(clk), .rst(rst), .instrValid(instrValid),
    .instrWord(instrWord), .irqControlSecond(irqControlSecond), .timerCEvent(timerCEvent),
    .timerDEvent(timerDEvent), .timerCIrqFlag_r(timerCIrqFlag_r),
    .timerDIrqFlag_r(timerDIrqFlag_r), .skipNext_r(skipNext_r), .sysResetReq_r(sysResetReq_r),
    .opDone_r(opDone_r), .opClass_r(opClass_r), .instrCycle_r(instrCycle_r));
